/* File: sim/plc_host_model.sv */
module plc_host_model (
   input  wire logic i_clock,                // device clock, paces the pins
   output logic      o_backlight_serial_in,  // backlight pulse pin
   output logic      o_flash_serial_in       // flash pulse pin
);
   timeunit 1ns;
   timeprecision 100ps;

   // gpio idles low after power-up, so the device enters shutdown once the off timeout runs out
   initial begin
      o_backlight_serial_in = 1'b0;
      o_flash_serial_in     = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   task automatic drive(input bit ch, input logic v);
      @(posedge i_clock);
      if (ch)
         o_flash_serial_in <= v;
      else
         o_backlight_serial_in <= v;
   endtask : drive

   // both pins to one level; both low for long enough asks for shutdown
   task automatic rest(input logic v);
      @(posedge i_clock);
      o_backlight_serial_in <= v;
      o_flash_serial_in     <= v;
   endtask : rest

   // exactly n rising edges, w cycles low and w high, then left high to latch
   task automatic send(input bit ch, input int n, input int w);
      for (int i = 0; i < n; i++) begin
         drive(ch, 1'b0);
         repeat (w - 1) @(posedge i_clock);
         drive(ch, 1'b1);
         repeat (w - 1) @(posedge i_clock);
      end
   endtask : send
endmodule : plc_host_model

/* File: sim/pulse_count_led_level_control_test.sv */
module pulse_count_led_level_control_test;
   timeunit 1ns;
   timeprecision 100ps;
   import plc_pkg::*;

   // shortened timeouts keep the run near 62k cycles; latch hold stays full length
   localparam int unsigned FT   = 200;
   localparam int unsigned OFF  = 50;
   localparam int          HOLD = 20000;
   localparam logic [9:0]  BL_PCT [16] = '{10'h3e8, 10'h334, 10'h2bc, 10'h24e, 10'h1ec,
      10'h19a, 10'h14a, 10'h11a, 10'h0eb, 10'h0bb, 10'h09a, 10'h07b, 10'h04d, 10'h029,
      10'h018, 10'h002};
   localparam logic [9:0]  FL_PCT [16] = '{10'h3e8, 10'h32a, 10'h2d0, 10'h294, 10'h258,
      10'h20d, 10'h1ce, 10'h19e, 10'h16e, 10'h13d, 10'h11d, 10'h0fa, 10'h0d9, 10'h0b8,
      10'h0a7, 10'h096};

   logic        i_clock, i_nrst, i_backlight_serial_in, i_flash_serial_in;
   logic        i_regulator_enable, i_timer_cap_grounded, i_wr, i_rd;
   logic        o_irq, o_regulator_a, o_regulator_b, o_shutdown;
   logic [3:0]  i_bl_sink_at_rail, i_fl_sink_at_rail, i_addr, bl_sinks, fl_sinks;
   logic [3:0]  o_backlight_sinks, o_flash_sinks;
   logic [4:0]  o_backlight_level, o_flash_level;
   logic [7:0]  i_wdata, o_rdata;
   logic [9:0]  o_backlight_pct, o_flash_pct;
   logic [31:0] seed = 32'h0000_230c;
   int          miscompares = 0;
   int          n_checks = 0;

   plc_top #(.FLASH_TIMER_CYCLES(FT), .OFF_CYCLES(OFF)) u_plc_top (
      .i_clock(i_clock), .i_nrst(i_nrst),
      .i_backlight_serial_in(i_backlight_serial_in), .i_flash_serial_in(i_flash_serial_in),
      .i_regulator_enable(i_regulator_enable), .i_timer_cap_grounded(i_timer_cap_grounded),
      .i_bl_sink_at_rail(i_bl_sink_at_rail), .i_fl_sink_at_rail(i_fl_sink_at_rail),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .o_irq(o_irq), .o_backlight_level(o_backlight_level), .o_flash_level(o_flash_level),
      .o_backlight_pct(o_backlight_pct), .o_flash_pct(o_flash_pct),
      .o_backlight_sinks(o_backlight_sinks), .o_flash_sinks(o_flash_sinks),
      .o_regulator_a(o_regulator_a), .o_regulator_b(o_regulator_b), .o_shutdown(o_shutdown));

   plc_host_model u_plc_host_model (
      .i_clock(i_clock), .o_backlight_serial_in(i_backlight_serial_in),
      .o_flash_serial_in(i_flash_serial_in));

   initial begin
      i_clock = 1'b0;
      forever #12.5 i_clock = ~i_clock;
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   function automatic logic [4:0] wrap(input int n);
      return 5'((n - 1) % 16 + 1);
   endfunction : wrap

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic end_of_test();
      $display("checks %0d, mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : end_of_test

   // leaves time one step past an edge, where outputs have settled
   task automatic tick(input int n);
      repeat (n) @(posedge i_clock);
      #1;
   endtask : tick

   task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_clock);
      i_wr    <= 1'b1;
      i_addr  <= a;
      i_wdata <= d;
      @(posedge i_clock);
      i_wr    <= 1'b0;
   endtask : reg_wr

   task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge i_clock);
      i_rd   <= 1'b1;
      i_addr <= a;
      @(posedge i_clock);
      i_rd   <= 1'b0;
      #1;
      d = o_rdata;
   endtask : reg_rd

   // counts cycles from the return of send, w - 1 cycles into the last high phase, until the level moves
   task automatic wait_level(input bit ch, input logic [4:0] exp);
      int t;
      t = 0;
      #1;
      while ((ch ? o_flash_level : o_backlight_level) !== exp && t < HOLD + 20) begin
         @(posedge i_clock);
         #1;
         t++;
      end
      check(ch ? o_flash_level : o_backlight_level, exp);
      check(t > HOLD - 50 && t < HOLD + 20, 1'b1);
   endtask : wait_level

   // both channels programmed at once, each judged against its own edge count
   task automatic phase(input int bn, input int bw, input int fn, input int fw, input bit gnd);
      logic [4:0] be, fe;
      logic [7:0] rd;
      be = wrap(bn);
      fe = wrap(fn);
      @(posedge i_clock);
      i_timer_cap_grounded <= gnd;
      u_plc_host_model.rest(1'b1);
      tick(5);
      fork
         begin
            u_plc_host_model.send(1'b0, bn, bw);
            wait_level(1'b0, be);
            check(o_backlight_pct, BL_PCT[be - 1]);
            check(o_backlight_sinks, bl_sinks);
         end
         begin
            u_plc_host_model.send(1'b1, fn, fw);
            wait_level(1'b1, fe);
            check(o_flash_pct, FL_PCT[fe - 1]);
            check(o_flash_sinks, fl_sinks);
            if (gnd) begin
               tick(FT + 50);
               check(o_flash_sinks, fl_sinks);
            end else begin
               reg_rd(4'h2, rd);
               check(rd, {3'b100, fe});
               tick(FT - 20);
               check(o_flash_sinks, fl_sinks);
               tick(30);
               check(o_flash_sinks, 4'h0);
            end
         end
      join
   endtask : phase

   ////////////////////////////////////////////////////////////////////////////////////////////
   initial begin : main
      logic [7:0] rd;
      i_nrst               = 1'b0;
      i_regulator_enable   = 1'b0;
      i_timer_cap_grounded = 1'b0;
      i_bl_sink_at_rail    = 4'h0;
      i_fl_sink_at_rail    = 4'h0;
      i_addr               = 4'h0;
      i_wdata              = 8'h00;
      i_wr                 = 1'b0;
      i_rd                 = 1'b0;
      bl_sinks             = 4'hf;
      fl_sinks             = 4'hf;
      repeat (10) @(posedge i_clock);
      i_nrst <= 1'b1;
      tick(1);
      check({o_backlight_level, o_flash_level, o_flash_sinks}, 14'h0000);
      reg_rd(4'h0, rd);
      check(rd, 8'h00);
      reg_rd(4'h1, rd);
      check(rd, 8'h00);
      tick(OFF + 10);
      check(o_shutdown, 1'b1);
      for (int i = 0; i < 4; i++) begin
         @(posedge i_clock);
         i_regulator_enable <= i[0];
         tick(6);
         check({o_regulator_a, o_regulator_b}, {2{i[0]}});
      end
      phase(int'(rnd() % 15) + 1, int'(rnd() % 19) + 2, int'(rnd() % 15) + 2,
            int'(rnd() % 19) + 2, 1'b0);
      reg_rd(4'h0, rd);
      check(rd, 8'h02);
      check(o_irq, 1'b0);
      reg_wr(4'h1, 8'h03);
      tick(3);
      check(o_irq, 1'b1);
      reg_wr(4'h0, 8'h02);
      tick(3);
      check(o_irq, 1'b0);
      reg_wr(4'h7, 8'hff);
      reg_rd(4'h9, rd);
      check(rd, 8'h00);
      reg_rd(4'h1, rd);
      check(rd, 8'h03);
      // slow backlight, fast flash past sixteen, timer disabled, two sinks on the rail
      @(posedge i_clock);
      i_bl_sink_at_rail <= 4'h2;
      i_fl_sink_at_rail <= 4'h8;
      bl_sinks = 4'hd;
      fl_sinks = 4'h7;
      phase(16, 40, 17, 2, 1'b1);
      check(o_irq, 1'b1);
      reg_rd(4'h3, rd);
      check(rd, 8'h82);
      @(posedge i_clock);
      i_bl_sink_at_rail <= 4'h0;
      i_fl_sink_at_rail <= 4'h0;
      tick(5);
      reg_wr(4'h0, 8'h03);
      tick(3);
      check(o_irq, 1'b0);
      check({o_backlight_sinks, o_flash_sinks}, 8'hd7);
      // pending count must not survive shutdown
      u_plc_host_model.send(1'b0, 4, 5);
      u_plc_host_model.rest(1'b0);
      tick(OFF + 10);
      check(o_shutdown, 1'b1);
      check({o_backlight_level, o_flash_level}, 10'h000);
      reg_rd(4'h2, rd);
      check(rd, 8'h40);
      phase(3, int'(rnd() % 19) + 2, 16, 3, 1'b0);
      check(o_shutdown, 1'b0);
      end_of_test();
   end

   initial begin : watchdog
      repeat (90000) @(posedge i_clock);
      miscompares++;
      end_of_test();
   end
endmodule : pulse_count_led_level_control_test

/* File: src/plc_ch_if.sv */
interface plc_ch_if;
   import plc_pkg::*;
   logic      serial_sync;
   logic      shutdown;
   plc_code_t level;
   logic      latch_pulse;
   modport ch  (input serial_sync, input shutdown, output level, output latch_pulse);
   modport top (output serial_sync, output shutdown, input level, input latch_pulse);
endinterface : plc_ch_if

/* File: src/plc_params.svh */
`ifndef PLC_PARAMS_SVH
`define PLC_PARAMS_SVH
// internal clock rate in kHz (40 MHz)
`define PLC_CLK_KHZ          40000
// latch hold time and off timeout, microseconds
`define PLC_LATCH_HOLD_US    500
`define PLC_OFF_TIMEOUT_US   500
// each time rounds down to whole cycles
`define PLC_LATCH_CYCLES     ((`PLC_LATCH_HOLD_US * `PLC_CLK_KHZ) / 1000)
`define PLC_OFF_CYCLES       ((`PLC_OFF_TIMEOUT_US * `PLC_CLK_KHZ) / 1000)
// flash timer: seconds per microfarad, capacitance in nanofarads
`define PLC_FT_SEC_PER_UF    10
`define PLC_FT_CAP_NF        100
// cycles = 10 s/uF * nF/1000 * 40e6
`define PLC_FT_CYCLES        ((`PLC_FT_SEC_PER_UF * `PLC_FT_CAP_NF * `PLC_CLK_KHZ) / 1)
`define PLC_CODE_MAX         5'h10
`define PLC_NUM_SINKS        4
`define PLC_INT_UNUSED_BIT   0
`define PLC_INT_EXPIRE_BIT   1
`endif

/* File: src/plc_pkg.sv */
package plc_pkg;
   typedef logic [4:0]  plc_code_t;
   typedef logic [14:0] plc_cnt_t;
   typedef logic [9:0]  plc_pct_t;
endpackage : plc_pkg

/* File: src/plc_serial_ch.sv */
`include "plc_params.svh"
module plc_serial_ch
   import plc_pkg::*;
(
   input  wire logic i_clock,   // internal clock
   input  wire logic i_nrst,    // async reset, active low
   plc_ch_if.ch      chan       // channel link to top
);
   typedef struct packed {
      logic      prev;
      plc_code_t count;
      plc_code_t level;
      plc_cnt_t  high_cnt;
      logic      armed;
      logic      latch_pulse;
   } plc_ch_s;

   plc_ch_s state, next_state;

   always_comb begin
      next_state = state;
      next_state.latch_pulse = 1'b0;
      next_state.prev = chan.serial_sync;
      if (chan.shutdown) begin
         next_state.count = '0;
         next_state.level = '0;
         next_state.armed = 1'b0;
         next_state.high_cnt = '0;
      end else if (chan.serial_sync && !state.prev) begin
         // any edge rate counts, no bit period
         next_state.count = (state.count == `PLC_CODE_MAX) ? 5'h01 : state.count + 5'h01;
         next_state.high_cnt = '0;
         next_state.armed = 1'b1;
      end else if (chan.serial_sync && state.armed) begin
         // sync, edge and output stages come out of the hold so pin to level fits
         if (state.high_cnt == plc_cnt_t'(`PLC_LATCH_CYCLES - 5)) begin
            next_state.level = state.count;
            next_state.count = '0;
            next_state.armed = 1'b0;
            next_state.latch_pulse = 1'b1;
         end else begin
            next_state.high_cnt = state.high_cnt + plc_cnt_t'(1);
         end
      end else if (!chan.serial_sync) begin
         next_state.high_cnt = '0;
      end
   end

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign chan.level = state.level;
   assign chan.latch_pulse = state.latch_pulse;

   a_latch_after_hold: assert property (@(posedge i_clock) disable iff (!i_nrst)
      state.latch_pulse |-> state.count == '0 && state.level != '0)
      else $error("latch did not clear counter");
   a_count_wraps: assert property (@(posedge i_clock) disable iff (!i_nrst)
      (!chan.shutdown && chan.serial_sync && !state.prev && state.count == `PLC_CODE_MAX)
      |=> state.count == 5'h01)
      else $error("count did not wrap to one");
   a_count_bounded: assert property (@(posedge i_clock) disable iff (!i_nrst)
      state.count <= `PLC_CODE_MAX)
      else $error("count out of range");
endmodule : plc_serial_ch

/* File: src/plc_top.sv */
`include "plc_params.svh"
module plc_top
   import plc_pkg::*;
#(
   parameter int unsigned FLASH_TIMER_CYCLES = `PLC_FT_CYCLES, // flash timeout
   parameter int unsigned OFF_CYCLES         = `PLC_OFF_CYCLES // shutdown timeout
) (
   input  wire logic       i_clock,                // 40 MHz clock
   input  wire logic       i_nrst,                 // async reset, active low
   input  wire logic       i_backlight_serial_in,  // backlight pulse pin
   input  wire logic       i_flash_serial_in,      // flash pulse pin
   input  wire logic       i_regulator_enable,     // shared regulator on pin
   input  wire logic       i_timer_cap_grounded,   // timing cap tied low
   input  wire logic [3:0] i_bl_sink_at_rail,      // backlight sink on rail
   input  wire logic [3:0] i_fl_sink_at_rail,      // flash sink on rail
   input  wire logic [3:0] i_addr,                 // register address
   input  wire logic [7:0] i_wdata,                // write data
   input  wire logic       i_wr,                   // write strobe
   input  wire logic       i_rd,                   // read strobe
   output logic      [7:0] o_rdata,                // read data
   output logic            o_irq,                  // level interrupt
   output logic      [4:0] o_backlight_level,      // active backlight code
   output logic      [4:0] o_flash_level,          // active flash code
   output logic      [9:0] o_backlight_pct,        // percent x10
   output logic      [9:0] o_flash_pct,            // percent x10
   output logic      [3:0] o_backlight_sinks,      // backlight sink enables
   output logic      [3:0] o_flash_sinks,          // flash sink enables
   output logic            o_regulator_a,          // regulator a on
   output logic            o_regulator_b,          // regulator b on
   output logic            o_shutdown              // device in shutdown
);
   localparam logic [3:0] ADDR_STATUS = 4'h0;
   localparam logic [3:0] ADDR_MASK   = 4'h1;
   localparam logic [3:0] ADDR_LEVELS = 4'h2;

   ////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [1:0] bl_sync;
      logic [1:0] fl_sync;
      logic [1:0] en_sync;
      logic [1:0] cap_sync;
      logic [3:0] bl_rail_s1;
      logic [3:0] bl_rail_s2;
      logic [3:0] fl_rail_s1;
      logic [3:0] fl_rail_s2;
      logic [3:0] bl_dead;
      logic [3:0] fl_dead;
      logic [31:0] ft_cnt;
      logic        ft_run;
      logic        ft_expired;
      logic [14:0] off_cnt;
      logic        shut;
      logic [1:0]  status;
      logic [1:0]  mask;
      logic [7:0]  rdata;
      logic        irq;
      plc_code_t   bl_level;
      plc_code_t   fl_level;
      plc_pct_t    bl_pct;
      plc_pct_t    fl_pct;
      logic [3:0]  bl_sinks;
      logic [3:0]  fl_sinks;
      logic        reg_on;
   } plc_top_s;

   plc_top_s state, next_state;

   plc_ch_if bl_if ();
   plc_ch_if fl_if ();

   // one instance each keeps the channels free of shared state
   plc_serial_ch u_bl (.i_clock(i_clock), .i_nrst(i_nrst), .chan(bl_if.ch));
   plc_serial_ch u_fl (.i_clock(i_clock), .i_nrst(i_nrst), .chan(fl_if.ch));

   assign bl_if.serial_sync = state.bl_sync[1];
   assign fl_if.serial_sync = state.fl_sync[1];
   assign bl_if.shutdown = state.shut;
   assign fl_if.shutdown = state.shut;

   ////////////////////////////////////////////////////////////////////////////
   // tenths of a percent; code 0 means off
   function automatic plc_pct_t bl_map(input plc_code_t c);
      case (c)
         5'h01:   bl_map = 10'd1000;
         5'h02:   bl_map = 10'd820;
         5'h03:   bl_map = 10'd700;
         5'h04:   bl_map = 10'd590;
         5'h05:   bl_map = 10'd492;
         5'h06:   bl_map = 10'd410;
         5'h07:   bl_map = 10'd330;
         5'h08:   bl_map = 10'd282;
         5'h09:   bl_map = 10'd235;
         5'h0a:   bl_map = 10'd187;
         5'h0b:   bl_map = 10'd154;
         5'h0c:   bl_map = 10'd123;
         5'h0d:   bl_map = 10'd77;
         5'h0e:   bl_map = 10'd41;
         5'h0f:   bl_map = 10'd24;
         5'h10:   bl_map = 10'd2;
         default: bl_map = 10'd0;
      endcase
   endfunction : bl_map

   function automatic plc_pct_t fl_map(input plc_code_t c);
      case (c)
         5'h01:   fl_map = 10'd1000;
         5'h02:   fl_map = 10'd810;
         5'h03:   fl_map = 10'd720;
         5'h04:   fl_map = 10'd660;
         5'h05:   fl_map = 10'd600;
         5'h06:   fl_map = 10'd525;
         5'h07:   fl_map = 10'd462;
         5'h08:   fl_map = 10'd414;
         5'h09:   fl_map = 10'd366;
         5'h0a:   fl_map = 10'd317;
         5'h0b:   fl_map = 10'd285;
         5'h0c:   fl_map = 10'd250;
         5'h0d:   fl_map = 10'd217;
         5'h0e:   fl_map = 10'd184;
         5'h0f:   fl_map = 10'd167;
         5'h10:   fl_map = 10'd150;
         default: fl_map = 10'd0;
      endcase
   endfunction : fl_map

   ////////////////////////////////////////////////////////////////////////////
   logic [1:0] ev;
   logic       fl_on;

   always_comb begin
      next_state = state;
      ev = 2'b00;
      next_state.bl_sync    = {state.bl_sync[0], i_backlight_serial_in};
      next_state.fl_sync    = {state.fl_sync[0], i_flash_serial_in};
      next_state.en_sync    = {state.en_sync[0], i_regulator_enable};
      next_state.cap_sync   = {state.cap_sync[0], i_timer_cap_grounded};
      next_state.bl_rail_s1 = i_bl_sink_at_rail;
      next_state.bl_rail_s2 = state.bl_rail_s1;
      next_state.fl_rail_s1 = i_fl_sink_at_rail;
      next_state.fl_rail_s2 = state.fl_rail_s1;

      // sticky until reset: a sink seen on the rail never comes back
      next_state.bl_dead = state.bl_dead | state.bl_rail_s2;
      next_state.fl_dead = state.fl_dead | state.fl_rail_s2;
      if ((state.bl_rail_s2 & ~state.bl_dead) != 4'h0 ||
          (state.fl_rail_s2 & ~state.fl_dead) != 4'h0) begin
         ev[`PLC_INT_UNUSED_BIT] = 1'b1;
      end

      // both low: shutdown after the off timeout
      if (!state.bl_sync[1] && !state.fl_sync[1]) begin
         if (state.off_cnt == 15'(OFF_CYCLES - 1)) begin
            next_state.shut = 1'b1;
         end else begin
            next_state.off_cnt = state.off_cnt + 15'h0001;
         end
      end else begin
         next_state.off_cnt = 15'h0000;
         next_state.shut = 1'b0;
      end

      next_state.bl_level = bl_if.level;
      next_state.fl_level = fl_if.level;
      next_state.bl_pct = bl_map(bl_if.level);
      next_state.fl_pct = fl_map(fl_if.level);

      // flash timer
      if (state.shut) begin
         next_state.ft_run = 1'b0;
         next_state.ft_expired = 1'b0;
         next_state.ft_cnt = 32'h0000_0000;
      end else if (fl_if.latch_pulse) begin
         next_state.ft_run = 1'b1;
         next_state.ft_expired = 1'b0;
         next_state.ft_cnt = 32'h0000_0000;
      end else if (state.ft_run && !state.cap_sync[1]) begin
         if (state.ft_cnt == 32'(FLASH_TIMER_CYCLES - 1)) begin
            next_state.ft_run = 1'b0;
            next_state.ft_expired = 1'b1;
            ev[`PLC_INT_EXPIRE_BIT] = 1'b1;
         end else begin
            next_state.ft_cnt = state.ft_cnt + 32'h0000_0001;
         end
      end

      fl_on = (fl_if.level != 5'h00) && !next_state.ft_expired;
      next_state.bl_sinks = (bl_if.level != 5'h00) ? ~next_state.bl_dead : 4'h0;
      next_state.fl_sinks = fl_on ? ~next_state.fl_dead : 4'h0;
      next_state.reg_on = state.en_sync[1];

      // register port: set wins over a same-cycle clear
      if (i_wr && i_addr == ADDR_MASK) begin
         next_state.mask = i_wdata[1:0];
      end
      if (i_wr && i_addr == ADDR_STATUS) begin
         next_state.status = (state.status & ~i_wdata[1:0]) | ev;
      end else begin
         next_state.status = state.status | ev;
      end
      next_state.rdata = 8'h00;
      if (i_rd) begin
         case (i_addr)
            ADDR_STATUS: next_state.rdata = {6'h00, state.status};
            ADDR_MASK:   next_state.rdata = {6'h00, state.mask};
            ADDR_LEVELS: next_state.rdata = {state.ft_run, state.shut, 1'b0, state.fl_level};
            4'h3:        next_state.rdata = {state.fl_dead, state.bl_dead};
            default:     next_state.rdata = 8'h00;
         endcase
      end
      next_state.irq = (next_state.status & next_state.mask) != 2'b00;
   end

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign o_rdata           = state.rdata;
   assign o_irq             = state.irq;
   assign o_backlight_level = state.bl_level;
   assign o_flash_level     = state.fl_level;
   assign o_backlight_pct   = state.bl_pct;
   assign o_flash_pct       = state.fl_pct;
   assign o_backlight_sinks = state.bl_sinks;
   assign o_flash_sinks     = state.fl_sinks;
   assign o_regulator_a     = state.reg_on;
   assign o_regulator_b     = state.reg_on;
   assign o_shutdown        = state.shut;

   ////////////////////////////////////////////////////////////////////////////
   a_shutdown_clears: assert property (@(posedge i_clock) disable iff (!i_nrst)
      state.shut |=> ##1 bl_if.level == 5'h00 && fl_if.level == 5'h00)
      else $error("shutdown did not clear levels");
   a_shut_needs_low: assert property (@(posedge i_clock) disable iff (!i_nrst)
      $rose(state.shut) |-> $past(!state.bl_sync[1] && !state.fl_sync[1]))
      else $error("shutdown without both inputs low");
   a_regs_together: assert property (@(posedge i_clock) disable iff (!i_nrst)
      o_regulator_a == o_regulator_b)
      else $error("regulators differ");
   a_dead_sink_off: assert property (@(posedge i_clock) disable iff (!i_nrst)
      (state.bl_dead & state.bl_sinks) == 4'h0 &&
      (state.fl_dead & state.fl_sinks) == 4'h0)
      else $error("dead sink enabled");
   a_dead_sticks: assert property (@(posedge i_clock) disable iff (!i_nrst)
      state.bl_rail_s2[0] |=> state.bl_dead[0] [*8])
      else $error("dead flag released");
   a_flash_starts: assert property (@(posedge i_clock) disable iff (!i_nrst)
      fl_if.latch_pulse && !state.shut |=> state.ft_run && state.fl_sinks != 4'h0
      || state.fl_dead == 4'hf)
      else $error("flash timer not started");
   a_expired_off: assert property (@(posedge i_clock) disable iff (!i_nrst)
      state.ft_expired |-> state.fl_sinks == 4'h0)
      else $error("flash on after expiry");
   a_bl_pct_map: assert property (@(posedge i_clock) disable iff (!i_nrst)
      bl_if.level == 5'h05 |=> state.bl_pct == 10'd492)
      else $error("backlight code 5 map wrong");
   a_fl_pct_map: assert property (@(posedge i_clock) disable iff (!i_nrst)
      fl_if.level == 5'h06 |=> state.fl_pct == 10'd525)
      else $error("flash code 6 map wrong");
   a_timer_hold_gnd: assert property (@(posedge i_clock) disable iff (!i_nrst)
      state.cap_sync[1] && !fl_if.latch_pulse && !state.shut |=> $stable(state.ft_cnt))
      else $error("timer ran with cap grounded");
endmodule : plc_top
